// ### rtl/pin_route_decode.sv
// registered decode of latched straps into pin routing
`timescale 1ns/1ps
`default_nettype none
module pin_route_decode (
    input  wire logic       sys_clk,
    input  wire logic       width_strap,
    input  wire logic       eth_strap,
    output logic            host_enable_q,
    output logic            host_wide_q,
    output logic            host_lower_en_q,
    output logic            host_upper_en_q,
    output logic            eth_enable_q,
    output logic            eth_upper_en_q
);
    logic host_enable_d;
    logic host_wide_d;
    logic host_lower_en_d;
    logic host_upper_en_d;
    logic eth_enable_d;
    logic eth_upper_en_d;
    always_comb begin
        eth_enable_d    = eth_strap;
        eth_upper_en_d  = eth_strap;
        host_enable_d   = !(eth_strap && width_strap);
        host_wide_d     = width_strap && !eth_strap;
        host_lower_en_d = host_enable_d;
        host_upper_en_d = host_wide_d;
    end
    always_ff @(posedge sys_clk) begin
        host_enable_q   <= host_enable_d;
        host_wide_q     <= host_wide_d;
        host_lower_en_q <= host_lower_en_d;
        host_upper_en_q <= host_upper_en_d;
        eth_enable_q    <= eth_enable_d;
        eth_upper_en_q  <= eth_upper_en_d;
    end
endmodule : pin_route_decode
`default_nettype wire

// ### rtl/reset_strap_config_select.sv
// reset strap capture, decode and configuration block registers
`timescale 1ns/1ps
`default_nettype none
module reset_strap_config_select #(
    parameter logic [31:0] CHIP_IDENTITY = 32'h0A5C3001 // arbitrary value
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [3:0]  ext_mem_addr_pins,
    input  wire logic        endian_strap,
    input  wire logic        host_width_strap,
    input  wire logic        ethernet_select_strap,
    input  wire logic        gpio_bank_zero_pin0,
    input  wire logic        cfg_sel,
    input  wire logic        cfg_write,
    input  wire logic [31:0] cfg_addr,
    input  wire logic [31:0] cfg_wdata,
    output logic      [31:0] cfg_rdata,
    output logic             cfg_ack,
    output logic             byte_order_mode,
    output logic      [1:0]  boot_mode,
    output logic             boot_mode_reserved,
    output logic      [1:0]  ext_mem_clock_source,
    output logic             ext_mem_clock_reserved,
    output logic             strap_invalid,
    output logic             host_port_enable,
    output logic             host_port_width,
    output logic             host_lower_drive_en,
    output logic             host_upper_drive_en,
    output logic             ethernet_mac_enable,
    output logic             mdio_enable,
    output logic             ethernet_upper_pins_en,
    output logic             always_on_enable,
    output logic             video_port_a_enable,
    output logic             video_port_b_enable,
    output logic             buffered_serial_zero_enable,
    output logic             spare_serial_enable,
    output logic             audio_serial_zero_enable,
    output logic             two_wire_zero_enable
);
    import strap_cfg_pkg::*;

    // ==========================================
    // strap capture
    logic [3:0]  addr_q;
    logic        endian_q;
    logic        width_q;
    logic        eth_q;
    logic        invalid_q;
    logic        eth_route_q;

    strap_latch #(
        .ADDR_WIDTH (STRAP_ADDR_WIDTH)
    ) u_latch (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .addr_pins  (ext_mem_addr_pins),
        .endian_pin (endian_strap),
        .width_pin  (host_width_strap),
        .eth_pin    (ethernet_select_strap),
        .gpio_pin   (gpio_bank_zero_pin0),
        .addr_q     (addr_q),
        .endian_q   (endian_q),
        .width_q    (width_q),
        .eth_q      (eth_q),
        .invalid_q  (invalid_q)
    );

    pin_route_decode u_route (
        .sys_clk         (sys_clk),
        .width_strap     (width_q),
        .eth_strap       (eth_q),
        .host_enable_q   (host_port_enable),
        .host_wide_q     (host_port_width),
        .host_lower_en_q (host_lower_drive_en),
        .host_upper_en_q (host_upper_drive_en),
        .eth_enable_q    (ethernet_mac_enable),
        .eth_upper_en_q  (eth_route_q)
    );

    assign ethernet_upper_pins_en = eth_route_q;

    // ==========================================
    // mode decode
    function automatic logic boot_is_reserved(input logic [1:0] code);
        return code == BOOT_RESERVED;
    endfunction : boot_is_reserved

    function automatic logic clock_is_reserved(input logic [1:0] code);
        return code == CLOCK_RESERVED;
    endfunction : clock_is_reserved

    logic       byte_order_d;
    logic [1:0] boot_d;
    logic       boot_res_d;
    logic [1:0] clock_d;
    logic       clock_res_d;
    logic       invalid_d;
    logic       mdio_d;
    logic       always_on_d;

    always_comb begin
        byte_order_d = endian_q;
        boot_d       = addr_q[3:2];
        boot_res_d   = boot_is_reserved(addr_q[3:2]);
        clock_d      = addr_q[1:0];
        clock_res_d  = clock_is_reserved(addr_q[1:0]);
        // a high gpio level is only reported; the board owns that pin
        invalid_d    = invalid_q;
        mdio_d       = eth_q;
        always_on_d  = 1'b1;
    end

    always_ff @(posedge sys_clk) begin
        byte_order_mode        <= byte_order_d;
        boot_mode              <= boot_d;
        boot_mode_reserved     <= boot_res_d;
        ext_mem_clock_source   <= clock_d;
        ext_mem_clock_reserved <= clock_res_d;
        strap_invalid          <= invalid_d;
        mdio_enable            <= mdio_d;
        always_on_enable       <= always_on_d;
    end

    // ==========================================
    // configuration bus slave
    function automatic logic block_hit(input logic [31:0] addr);
        return (addr & CFG_BLOCK_MASK) == CFG_BLOCK_BASE;
    endfunction : block_hit

    logic [31:0] periph_sel_q;
    logic [31:0] periph_sel_d;
    logic [31:0] rdata_d;
    logic        ack_d;
    logic [31:0] state_word;
    logic        sel_hit;
    logic        sel_write;

    always_comb begin
        sel_hit    = cfg_sel && block_hit(cfg_addr);
        sel_write  = sel_hit && cfg_write && cfg_addr[11:0] == PERIPH_SEL_OFFSET;
        state_word = 32'h00000000;
        state_word[STATE_ENDIAN_BIT]                    = endian_q;
        state_word[STATE_BOOT_LSB +: 2]                 = addr_q[3:2];
        state_word[STATE_CLOCK_LSB +: 2]                = addr_q[1:0];
        state_word[STATE_WIDTH_BIT]                     = width_q;
        state_word[STATE_ETH_BIT]                       = eth_q;
        state_word[STATE_INVALID_BIT]                   = invalid_q;
        periph_sel_d = periph_sel_q;
        if (rst) begin
            periph_sel_d = PERIPH_SEL_RESET;
        end else if (sel_write) begin
            // reserved bits never store, so they always read zero
            periph_sel_d = cfg_wdata & PERIPH_SEL_WRITABLE;
        end
        ack_d   = sel_hit && !rst;
        rdata_d = 32'h00000000;
        if (sel_hit && !cfg_write && !rst) begin
            unique case (cfg_addr[11:0])
                PERIPH_SEL_OFFSET:    rdata_d = periph_sel_q;
                DEVICE_STATE_OFFSET:  rdata_d = state_word;
                CHIP_IDENTITY_OFFSET: rdata_d = CHIP_IDENTITY;
                default:              rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        periph_sel_q <= periph_sel_d;
        cfg_rdata    <= rdata_d;
        cfg_ack      <= ack_d;
    end

    assign video_port_a_enable         = periph_sel_q[VIDEO_A_BIT];
    assign video_port_b_enable         = periph_sel_q[VIDEO_B_BIT];
    assign buffered_serial_zero_enable = periph_sel_q[SERIAL_ZERO_BIT];
    assign spare_serial_enable         = periph_sel_q[SPARE_SERIAL_BIT];
    assign audio_serial_zero_enable    = periph_sel_q[AUDIO_ZERO_BIT];
    assign two_wire_zero_enable        = periph_sel_q[TWO_WIRE_BIT];

    // ==========================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence periph_write_s;
        cfg_sel && cfg_write && block_hit(cfg_addr) && cfg_addr[11:0] == PERIPH_SEL_OFFSET;
    endsequence

    sequence settled_s;
        !rst ##1 !rst;
    endsequence

    strap_hold_a: assert property ($past(!rst) |-> $stable({addr_q, endian_q, width_q, eth_q}))
        else $error("latched straps changed outside reset");
    strap_capture_a: assert property ($past(rst) |-> addr_q == $past(ext_mem_addr_pins)
                                      && eth_q == $past(ethernet_select_strap))
        else $error("straps not captured at reset release");
    endian_map_a: assert property (settled_s |-> byte_order_mode == $past(endian_q))
        else $error("byte order does not follow endian strap");
    boot_map_a: assert property (settled_s |-> boot_mode == $past(addr_q[3:2])
                                 && boot_mode_reserved == ($past(addr_q[3:2]) == BOOT_RESERVED))
        else $error("boot mode decode wrong");
    clock_map_a: assert property (settled_s |-> ext_mem_clock_source == $past(addr_q[1:0])
                                  && ext_mem_clock_reserved == ($past(addr_q[1:0]) == CLOCK_RESERVED))
        else $error("memory clock select decode wrong");
    narrow_host_a: assert property (settled_s ##0 $past(!width_q && !eth_q) |->
                                    host_lower_drive_en && !host_upper_drive_en && !ethernet_upper_pins_en)
        else $error("narrow host port routing wrong");
    mac_off_a: assert property (settled_s ##0 $past(!eth_q) |-> !ethernet_mac_enable && !mdio_enable
                                && host_port_width == $past(width_q))
        else $error("mac not disabled with select low");
    shared_pins_a: assert property (settled_s ##0 $past(eth_q && !width_q) |-> host_port_enable
                                    && !host_port_width && ethernet_upper_pins_en && mdio_enable)
        else $error("shared pin routing wrong");
    host_off_a: assert property (settled_s ##0 $past(eth_q && width_q) |-> !host_port_enable
                                 && !host_lower_drive_en && ethernet_upper_pins_en)
        else $error("host port not disabled");
    always_on_a: assert property ($past(!rst) |-> always_on_enable)
        else $error("always available peripherals dropped");
    sel_write_a: assert property (periph_write_s |=> cfg_ack
                                  && periph_sel_q == ($past(cfg_wdata) & PERIPH_SEL_WRITABLE))
        else $error("selection register write lost");
    block_read_a: assert property (cfg_sel && !cfg_write && block_hit(cfg_addr)
                                   && cfg_addr[11:0] == CHIP_IDENTITY_OFFSET |=> cfg_ack && cfg_rdata == CHIP_IDENTITY)
        else $error("identity read wrong");
    sel_reset_a: assert property ($past(rst) |-> periph_sel_q == PERIPH_SEL_RESET
                                  && !video_port_a_enable && !two_wire_zero_enable)
        else $error("selection register reset value wrong");

    // ==========================================
    // bus, capture and routing checks
    sequence block_read_s;
        cfg_sel && !cfg_write && block_hit(cfg_addr);
    endsequence

    sequence block_write_s;
        cfg_sel && cfg_write && block_hit(cfg_addr);
    endsequence

    sequence idle_bus_s;
        !cfg_sel;
    endsequence

    miss_no_ack_a: assert property (cfg_sel && !block_hit(cfg_addr) |=> !cfg_ack)
        else $error("access outside block acknowledged");

    idle_quiet_a: assert property (idle_bus_s |=> !cfg_ack && cfg_rdata == 32'h00000000)
        else $error("bus answered without a request");

    ack_source_a: assert property (cfg_ack |-> $past(cfg_sel))
        else $error("acknowledge without a request");

    state_read_a: assert property (block_read_s ##0 (cfg_addr[11:0] == DEVICE_STATE_OFFSET) |=>
                                   cfg_rdata == {24'h000000, $past(invalid_q), $past(eth_q), $past(width_q),
                                                 $past(addr_q[1:0]), $past(addr_q[3:2]), $past(endian_q)})
        else $error("device state read wrong");

    hole_read_a: assert property (block_read_s ##0 (cfg_addr[11:0] != PERIPH_SEL_OFFSET
                                  && cfg_addr[11:0] != DEVICE_STATE_OFFSET
                                  && cfg_addr[11:0] != CHIP_IDENTITY_OFFSET) |=> cfg_ack && cfg_rdata == 32'h00000000)
        else $error("unmapped offset read not zero");

    sel_read_a: assert property (block_read_s ##0 (cfg_addr[11:0] == PERIPH_SEL_OFFSET) |=>
                                 cfg_ack && cfg_rdata == $past(periph_sel_q))
        else $error("selection register read wrong");

    reserved_zero_a: assert property ((periph_sel_q & ~PERIPH_SEL_WRITABLE) == 32'h00000000)
        else $error("reserved selection bits set");

    other_write_a: assert property (block_write_s ##0 (cfg_addr[11:0] != PERIPH_SEL_OFFSET) |=>
                                    cfg_ack && $stable(periph_sel_q))
        else $error("write to read-only offset had effect");

    write_ack_a: assert property (block_write_s |=> cfg_ack && cfg_rdata == 32'h00000000)
        else $error("write not acknowledged cleanly");

    sel_hold_a: assert property (!sel_write |=> $stable(periph_sel_q))
        else $error("selection register changed without a write");

    rdata_idle_a: assert property (!cfg_ack |-> cfg_rdata == 32'h00000000)
        else $error("read data not zero outside acknowledge");

    bus_reset_a: assert property ($past(rst) |-> !cfg_ack && cfg_rdata == 32'h00000000)
        else $error("bus busy straight after reset");

    invalid_capture_a: assert property ($past(rst) |-> invalid_q == $past(gpio_bank_zero_pin0)
                                        && endian_q == $past(endian_strap) && width_q == $past(host_width_strap))
        else $error("endian, width or gpio strap not captured");

    invalid_flag_a: assert property (settled_s |-> strap_invalid == $past(invalid_q))
        else $error("invalid strap flag does not follow gpio");

    invalid_hold_a: assert property ($past(!rst) |-> $stable(invalid_q))
        else $error("invalid flag changed outside reset");

    wide_host_a: assert property (settled_s ##0 $past(width_q && !eth_q) |-> host_port_width
                                  && host_lower_drive_en && host_upper_drive_en && !ethernet_upper_pins_en)
        else $error("wide host port routing wrong");

    mac_on_a: assert property (settled_s ##0 $past(eth_q) |-> ethernet_mac_enable && mdio_enable
                               && ethernet_upper_pins_en && !host_upper_drive_en)
        else $error("mac not enabled with select high");
endmodule : reset_strap_config_select
`default_nettype wire

// ### rtl/strap_cfg_pkg.sv
// constants for strap capture and peripheral selection
package strap_cfg_pkg;
    // ==========================================
    // configuration block map
    localparam logic [31:0] CFG_BLOCK_BASE       = 32'h01B3F000;
    localparam logic [31:0] CFG_BLOCK_MASK       = 32'hFFFFF000;
    localparam logic [11:0] PERIPH_SEL_OFFSET    = 12'h000;
    localparam logic [11:0] DEVICE_STATE_OFFSET  = 12'h004;
    localparam logic [11:0] CHIP_IDENTITY_OFFSET = 12'h008;
    // ==========================================
    // peripheral selection fields
    localparam int          AUDIO_ZERO_BIT       = 0;
    localparam int          SERIAL_ZERO_BIT      = 1;
    localparam int          SPARE_SERIAL_BIT     = 2;
    localparam int          TWO_WIRE_BIT         = 3;
    localparam int          VIDEO_A_BIT          = 5;
    localparam int          VIDEO_B_BIT          = 6;
    localparam logic [31:0] PERIPH_SEL_RESET     = 32'h00000006;
    localparam logic [31:0] PERIPH_SEL_WRITABLE  = 32'h0000006F;
    // ==========================================
    // device state fields
    localparam int          STATE_ENDIAN_BIT     = 0;
    localparam int          STATE_BOOT_LSB       = 1;
    localparam int          STATE_CLOCK_LSB      = 3;
    localparam int          STATE_WIDTH_BIT      = 5;
    localparam int          STATE_ETH_BIT        = 6;
    localparam int          STATE_INVALID_BIT    = 7;
    // ==========================================
    // strap encodings
    localparam logic [1:0]  BOOT_NONE            = 2'h0;
    localparam logic [1:0]  BOOT_HOST            = 2'h1;
    localparam logic [1:0]  BOOT_RESERVED        = 2'h2;
    localparam logic [1:0]  BOOT_ROM8            = 2'h3;
    localparam logic [1:0]  CLOCK_EXT_INPUT      = 2'h0;
    localparam logic [1:0]  CLOCK_CPU_DIV4       = 2'h1;
    localparam logic [1:0]  CLOCK_CPU_DIV6       = 2'h2;
    localparam logic [1:0]  CLOCK_RESERVED       = 2'h3;
    localparam int          STRAP_ADDR_WIDTH     = 4;
endpackage : strap_cfg_pkg

// ### rtl/strap_latch.sv
// strap sampler that tracks pins in reset and freezes on release
`timescale 1ns/1ps
`default_nettype none
module strap_latch #(
    parameter int ADDR_WIDTH = strap_cfg_pkg::STRAP_ADDR_WIDTH
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic [ADDR_WIDTH-1:0] addr_pins,
    input  wire logic                  endian_pin,
    input  wire logic                  width_pin,
    input  wire logic                  eth_pin,
    input  wire logic                  gpio_pin,
    output logic      [ADDR_WIDTH-1:0] addr_q,
    output logic                       endian_q,
    output logic                       width_q,
    output logic                       eth_q,
    output logic                       invalid_q
);
    import strap_cfg_pkg::*;
    logic [ADDR_WIDTH+3:0] all_d;
    if (ADDR_WIDTH != STRAP_ADDR_WIDTH) begin : g_width_check
        $error("strap_latch: address strap width must be four");
    end
    // sync reset lets the pins themselves be the reset value
    always_comb begin
        if (rst) begin
            all_d = {addr_pins, endian_pin, width_pin, eth_pin, gpio_pin};
        end else begin
            all_d = {addr_q, endian_q, width_q, eth_q, invalid_q};
        end
    end
    always_ff @(posedge sys_clk) begin
        {addr_q, endian_q, width_q, eth_q, invalid_q} <= all_d;
    end
endmodule : strap_latch
`default_nettype wire

// ### tb/reset_strap_config_select_tb.sv
// self-checking bench for strap capture and configuration registers
`timescale 1ns/1ps
`default_nettype none
`define check(name, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; $display("mismatch %s expected %0h seen %0h", name, exp, got); end end
module reset_strap_config_select_tb;
    import strap_cfg_pkg::*;
    localparam logic [31:0] ID_CODE = 32'h00C0FFEE; // arbitrary value
    localparam logic [31:0] BASE    = 32'h01B3F000;
    logic sys_clk = 1'b0, rst = 1'b1, cfg_sel = 1'b0, cfg_write = 1'b0, wiggle = 1'b0;
    logic [31:0] cfg_addr = 32'h0, cfg_wdata = 32'h0, cfg_rdata, rd;
    logic [7:0] pull_value = 8'h0;
    logic [3:0] addr_pins;
    logic endian_pin, width_pin, eth_pin, gpio_pin, cfg_ack, ack, byte_order_mode, boot_mode_reserved;
    logic [1:0] boot_mode, ext_mem_clock_source;
    logic ext_mem_clock_reserved, strap_invalid, host_port_enable, host_port_width, host_lower_drive_en;
    logic host_upper_drive_en, ethernet_mac_enable, mdio_enable, ethernet_upper_pins_en, always_on_enable;
    logic video_port_a_enable, video_port_b_enable, buffered_serial_zero_enable, spare_serial_enable;
    logic audio_serial_zero_enable, two_wire_zero_enable;
    int n_mismatch = 0, n_checks = 0, cycles = 0;
    always #2 sys_clk = ~sys_clk;
    strap_resistors u_strap_resistors (.sys_clk(sys_clk), .rst(rst), .pull_value(pull_value), .wiggle(wiggle),
        .addr_pins(addr_pins), .endian_pin(endian_pin), .width_pin(width_pin), .eth_pin(eth_pin), .gpio_pin(gpio_pin));
    reset_strap_config_select #(.CHIP_IDENTITY(ID_CODE)) u_reset_strap_config_select (
        .sys_clk(sys_clk), .rst(rst), .ext_mem_addr_pins(addr_pins), .endian_strap(endian_pin),
        .host_width_strap(width_pin), .ethernet_select_strap(eth_pin), .gpio_bank_zero_pin0(gpio_pin),
        .cfg_sel(cfg_sel), .cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .byte_order_mode(byte_order_mode), .boot_mode(boot_mode),
        .boot_mode_reserved(boot_mode_reserved), .ext_mem_clock_source(ext_mem_clock_source),
        .ext_mem_clock_reserved(ext_mem_clock_reserved), .strap_invalid(strap_invalid),
        .host_port_enable(host_port_enable), .host_port_width(host_port_width),
        .host_lower_drive_en(host_lower_drive_en), .host_upper_drive_en(host_upper_drive_en),
        .ethernet_mac_enable(ethernet_mac_enable), .mdio_enable(mdio_enable),
        .ethernet_upper_pins_en(ethernet_upper_pins_en), .always_on_enable(always_on_enable),
        .video_port_a_enable(video_port_a_enable), .video_port_b_enable(video_port_b_enable),
        .buffered_serial_zero_enable(buffered_serial_zero_enable), .spare_serial_enable(spare_serial_enable),
        .audio_serial_zero_enable(audio_serial_zero_enable), .two_wire_zero_enable(two_wire_zero_enable));
    // ==========================================
    // shared tasks
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
        @(posedge sys_clk);
        #1;
        cfg_sel = 1'b1;
        cfg_write = wr;
        cfg_addr = addr;
        cfg_wdata = wd;
        @(posedge sys_clk);
        #1;
        cfg_sel = 1'b0;
        rd = cfg_rdata;
        ack = cfg_ack;
    endtask : bus
    task automatic reset_with(input logic [7:0] pulls);
        @(posedge sys_clk);
        #1;
        pull_value = pulls;
        rst = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : reset_with
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    // ==========================================
    // scenarios
    task automatic test_strap_decode;
        logic [3:0] a;
        logic e, w, en;
        logic [7:0] state;
        for (int j = 0; j < 64; j++) begin
            a = j[3:0];
            e = j[4];
            w = j[5];
            en = j[0] ^ j[5];
            reset_with({a, en, w, e, 1'b0});
            state = {1'b0, e, w, a[1:0], a[3:2], en};
            `check("endian", en, byte_order_mode);
            `check("boot", a[3:2], boot_mode);
            `check("boot_rsv", a[3:2] == BOOT_RESERVED, boot_mode_reserved);
            `check("clock", a[1:0], ext_mem_clock_source);
            `check("clock_rsv", a[1:0] == CLOCK_RESERVED, ext_mem_clock_reserved);
            `check("host_en", !(e && w), host_port_enable);
            `check("host_lower", !(e && w), host_lower_drive_en);
            `check("host_wide", w && !e, host_port_width);
            `check("host_upper", w && !e, host_upper_drive_en);
            `check("ethernet_select_strap", e, ethernet_mac_enable);
            `check("mdio_en", e, mdio_enable);
            `check("mac_upper", e, ethernet_upper_pins_en);
            `check("always_on", 1'b1, always_on_enable);
            bus(1'b0, BASE + 32'h4, 32'h0);
            `check("state", {24'h0, state}, rd);
            wiggle = 1'b1;
            repeat (6) @(posedge sys_clk);
            #1;
            wiggle = 1'b0;
            bus(1'b0, BASE + 32'h4, 32'h0);
            `check("state_held", {24'h0, state}, rd);
            `check("routing_held", {!(e && w), e, a}, {host_port_enable, ethernet_mac_enable, boot_mode, ext_mem_clock_source});
        end
    endtask : test_strap_decode
    task automatic test_invalid_gpio;
        reset_with(8'h01);
        `check("invalid", 1'b1, strap_invalid);
        bus(1'b0, BASE + 32'h4, 32'h0);
        `check("state_inv", 32'h00000080, rd);
        reset_with(8'h00);
        `check("valid", 1'b0, strap_invalid);
    endtask : test_invalid_gpio
    task automatic test_register_map;
        reset_with(8'h08);
        bus(1'b0, BASE, 32'h0);
        `check("sel_reset", PERIPH_SEL_RESET, rd);
        `check("video_off", 2'b00, {video_port_a_enable, video_port_b_enable});
        `check("two_wire_off", 1'b0, two_wire_zero_enable);
        `check("serial_on", 3'b110, {buffered_serial_zero_enable, spare_serial_enable, audio_serial_zero_enable});
        bus(1'b1, BASE, 32'hFFFFFFFF);
        `check("wr_ack", 1'b1, ack);
        `check("all_on", 6'h3F, {video_port_a_enable, video_port_b_enable, buffered_serial_zero_enable,
            spare_serial_enable, audio_serial_zero_enable, two_wire_zero_enable});
        bus(1'b0, BASE, 32'h0);
        `check("sel_mask", 32'h0000006F, rd);
        bus(1'b1, BASE, 32'h00000060);
        `check("video_only", 6'h30, {video_port_a_enable, video_port_b_enable, buffered_serial_zero_enable,
            spare_serial_enable, audio_serial_zero_enable, two_wire_zero_enable});
        bus(1'b1, BASE + 32'h4, 32'hFFFFFFFF);
        `check("state_ro_ack", 1'b1, ack);
        bus(1'b0, BASE + 32'h4, 32'h0);
        `check("state_ro", 32'h00000001, rd);
        bus(1'b0, BASE + 32'h8, 32'h0);
        `check("identity", ID_CODE, rd);
        bus(1'b0, BASE + 32'hFFC, 32'h0);
        `check("hole_ack", 1'b1, ack);
        `check("hole_zero", 32'h0, rd);
        bus(1'b0, BASE - 32'h4, 32'h0);
        `check("below_ack", 1'b0, ack);
        bus(1'b1, BASE + 32'h1000, 32'h0);
        `check("above_ack", 1'b0, ack);
        `check("above_noeffect", 1'b1, video_port_a_enable);
        reset_with(8'h00);
        bus(1'b0, BASE, 32'h0);
        `check("sel_rereset", PERIPH_SEL_RESET, rd);
    endtask : test_register_map
    // ==========================================
    // run control; a full run needs about 1140 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    initial begin
        test_strap_decode();
        test_invalid_gpio();
        test_register_map();
        wrap_up();
    end
endmodule : reset_strap_config_select_tb
`undef check
`default_nettype wire

// ### tb/strap_resistors.sv
// board strap resistor model for the configuration pins
`timescale 1ns/1ps
`default_nettype none
module strap_resistors (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [7:0] pull_value,
    input  wire logic       wiggle,
    output logic      [3:0] addr_pins,
    output logic            endian_pin,
    output logic            width_pin,
    output logic            eth_pin,
    output logic            gpio_pin
);
    // ==========================================
    // strap levels
    logic [7:0] toggle_q;
    always_ff @(posedge sys_clk) begin
        toggle_q <= rst ? pull_value : ~toggle_q;
    end
    // pins are reused after reset, so with wiggle set they move away from the strap levels
    assign {addr_pins, endian_pin, width_pin, eth_pin} = (wiggle && !rst) ? toggle_q[7:1] : pull_value[7:1];
    assign gpio_pin = (wiggle && !rst) ? toggle_q[0] : pull_value[0];
endmodule : strap_resistors
`default_nettype wire
